// [dv/dcsp_host_model.sv]
// Host serial port model that answers every frame the device opens
`timescale 1ns/100ps

module dcsp_host_model (
    // Clock
    input wire logic clk,
    // Serial port of the device
    input wire logic sclk,
    input wire logic sdofs,
    input wire logic sdo,
    output logic sdi,
    // Bench side
    input wire logic [31:0] tx_word,
    output logic [31:0] rx_word,
    output logic rx_done
);
    logic sclk_d = 1'b0;
    logic [5:0] cnt = 6'h00;
    logic [7:0] hc = 8'h00;
    logic [7:0] gap = 8'h00;

    // Quiet start at time zero, before the released line starts toggling
    initial begin
        sdi = 1'b0;
        rx_word = 32'h0;
        rx_done = 1'b0;
    end

    // One bit each way per serial clock rise, MSB first
    always @(posedge clk) begin
        sclk_d <= sclk;
        // Done in the cycle the device acts on its last bit
        rx_done <= (cnt == 6'h20) && (hc == gap - 8'h01);
        if (sclk && !sclk_d) begin
            hc <= 8'h00;
            gap <= hc; // Bit time less one, from rise to rise
            rx_word <= {rx_word[30:0], sdo};
            if (sdofs && cnt != 6'h10) begin
                // Only a frame opened by the device is answered
                cnt <= 6'h01;
                sdi <= tx_word[31];
            end else begin
                cnt <= cnt + 6'h01;
                sdi <= tx_word[5'h1f - cnt[4:0]];
            end
        end else begin
            if (hc != 8'hff) begin
                hc <= hc + 8'h01;
            end
            // Released line keeps changing so no stale bit is seen
            if (hc > 8'h14) begin
                sdi <= ~sdi;
            end
        end
    end
endmodule // dcsp_host_model

// [dv/dual_codec_serial_port_ctrl_bench.sv]
// Self-checking bench of the dual codec serial port controller
`timescale 1ns/100ps

module dual_codec_serial_port_ctrl_bench
    import dcsp_pkg::*;
;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    dcsp_bus_s bus = '0;
    logic [7:0] rdata;
    logic sclk, sdofs, sdo, sdi, rx_done;
    logic [1:0][15:0] enc_sample = '0;
    logic [1:0] enc_bit = '0;
    logic [1:0][15:0] interp_word = '0;
    dcsp_codec_s [1:0] codec;
    logic [31:0] tx_word = '0;
    logic [31:0] rx_word;
    logic [31:0] seed = 32'h5772;
    int fail_count = 0;
    int checks = 0;
    logic [2:0] mc [5] = '{3'h0, 3'h2, 3'h4, 3'h7, 3'h3};
    logic [1:0] sc [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2};
    int md [5] = '{1, 3, 5, 1, 4};
    int lt [5] = '{8, 12, 10, 4, 8};

    // 40 MHz clock
    always #12.5 clk = ~clk;

    dcsp_ctrl dut_u (.clk(clk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata),
        .sclk(sclk), .sdofs(sdofs), .sdo(sdo), .sdi(sdi),
        .enc_sample(enc_sample), .enc_bit(enc_bit),
        .interp_word(interp_word), .codec(codec));
    dcsp_host_model host_u (.clk(clk), .sclk(sclk), .sdofs(sdofs),
        .sdo(sdo), .sdi(sdi), .tx_word(tx_word), .rx_word(rx_word),
        .rx_done(rx_done));

    // Xorshift stimulus source
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Control word, write when rw is 0, readback when 1
    function automatic logic [15:0] ctl(input logic rw, input logic [2:0] a,
        input logic [7:0] d);
        return {1'b1, rw, 3'b000, a, d};
    endfunction

    // Analog tap gain in sixteenths
    function automatic int tap_gain(input logic [4:0] f);
        return (f < 5'h10) ? 16 - int'(f) : 15 - int'(f);
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("Checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask

    // Bounded wait for frame end or a serial clock level
    task automatic wait_sig(input bit on_sclk, input logic want,
        output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while ((on_sclk ? sclk : rx_done) !== want && n < 9000);
        if (n >= 9000) begin
            fail_count++;
            summarize();
        end
    endtask

    task automatic frame();
        int n;
        wait_sig(1'b0, 1'b1, n);
        @(posedge clk);
    endtask

    // Main sequence
    initial begin
        int i, c, n, h, q;
        logic [7:0] v, d, f, x;
        logic [15:0] g;
        logic [31:0] r;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        wr(5'h11, 8'hff);
        for (i = 0; i < 18; i++) begin
            rd(5'(i), x);
            chk("reset value", x, 32'h0);
        end
        $display("Test reset done");
        for (i = 0; i < 24; i++) begin
            c = i % 2;
            r = rnd();
            v = r[7:0];
            v[1] = (i % 3 != 0) || (i < 4);
            d = {r[15], 3'(i / 3), r[11:8]};
            f = r[23:16];
            if (i < 4) f[4:0] = 5'((i < 2) ? 15 * i : 15 * i - 14);
            if (i < 4) f[7] = 1'b0;
            wr(5'(c * 8 + 2), v);
            wr(5'(c * 8 + 3), d);
            wr(5'(c * 8 + 5), f);
            rd(5'(c * 8 + 3), x);
            chk("gain reg", x, d);
            chk("gain", codec[c].out_gain_db, 6 - 3 * int'(d[6:4]));
            chk("mute", codec[c].out_mute, d[7]);
            chk("ref out", codec[c].ref_out_en, v[6]);
            chk("tap link", codec[c].agt_connect, v[1] & f[5]);
            n = (v[1] && !f[7]) ? tap_gain(f[4:0]) : 0;
            chk("tap gain", codec[c].agt_gain, n);
        end
        $display("Test fields done");
        for (i = 0; i < 12; i++) begin
            c = i % 2;
            r = rnd();
            g = (i == 0) ? 16'h8000 : (i == 1) ? 16'h7fff : r[15:0];
            if (i == 2) g = 16'h0000;
            wr(5'(c * 8 + 6), g[15:8]);
            wr(5'(c * 8 + 7), g[7:0]);
            interp_word[c] <= r[31:16];
            enc_bit[c] <= r[i + 3];
            repeat (2) @(posedge clk);
            #1;
            n = int'($signed(r[31:16]));
            h = int'($signed(g));
            chk("tap sum", codec[c].dgt_sum, r[i + 3] ? n + h : n - h);
        end
        $display("Test digital tap done");
        frame();
        wr(5'h01, 8'h0f);
        wr(5'h09, 8'h0f);
        frame();
        tx_word <= {ctl(1'b0, 3'h3, 8'ha5), ctl(1'b0, 3'h6, 8'h3c)};
        frame();
        chk("control out", rx_word, 32'h0);
        rd(5'h0b, x);
        chk("serial write", x, 8'ha5);
        rd(5'h06, x);
        chk("serial write", x, 8'h3c);
        @(posedge clk);
        tx_word <= {16'h0123, ctl(1'b1, 3'h6, 8'h00)};
        frame();
        rd(5'h10, x);
        chk("status", x, 8'h02);
        rd(5'h09, x);
        chk("invalid ctl", x, 8'h0f);
        tx_word <= '0;
        frame();
        chk("readback", rx_word, 32'h0000c63c);
        $display("Test control mode done");
        wr(5'h00, 8'h01);
        wr(5'h08, 8'h01);
        r = rnd();
        enc_sample <= {r[15:0], r[31:16]};
        frame();
        r = rnd();
        tx_word <= r;
        frame();
        chk("dac two", codec[1].dac_word, r[31:16]);
        chk("dac one", codec[0].dac_word, r[15:0]);
        chk("samples", rx_word, {enc_sample[1], enc_sample[0]});
        $display("Test data mode done");
        wr(5'h00, 8'h03);
        wr(5'h08, 8'h03);
        frame();
        g = rnd() >> 16;
        tx_word <= {1'b0, g[14:0], ctl(1'b0, 3'h3, 8'h5a)};
        frame();
        chk("mixed dac", codec[1].dac_word, {g[14:0], 1'b0});
        r = {1'b0, enc_sample[1][15:1], 1'b0, enc_sample[0][15:1]};
        chk("mixed out", rx_word, r);
        rd(5'h03, x);
        chk("mixed ctl", x, 8'h5a);
        $display("Test mixed mode done");
        @(posedge clk);
        tx_word <= '0;
        for (i = 0; i < 5; i++) begin
            wr(5'h01, {1'b0, mc[i], sc[i], 2'b11});
            wr(5'h09, {1'b0, mc[i], sc[i], 2'b11});
            wait_sig(1'b0, 1'b1, n);
            wait_sig(1'b0, 1'b1, n);
            wait_sig(1'b0, 1'b1, n);
            chk("sample period", n, 256 * md[i]);
            wait_sig(1'b1, 1'b0, n);
            wait_sig(1'b1, 1'b1, n);
            wait_sig(1'b1, 1'b0, h);
            wait_sig(1'b1, 1'b1, q);
            chk("sclk high", h, lt[i] / 2);
            chk("bit time", h + q, lt[i]);
        end
        $display("Test dividers done");
        summarize();
    end
endmodule // dual_codec_serial_port_ctrl_bench

// [hw/dcsp_ctrl.sv]
// Serial port and control logic of the dual voice codec
`timescale 1ns/100ps
`include "dcsp_defs.svh"

module dcsp_ctrl
    import dcsp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Register port
    input wire dcsp_bus_s bus,
    output logic [7:0] rdata,
    // Serial port toward the host
    output logic sclk,
    output logic sdofs,
    output logic sdo,
    input wire logic sdi,
    // Codec data path
    input wire logic [1:0][15:0] enc_sample,
    input wire logic [1:0] enc_bit,
    input wire logic [1:0][15:0] interp_word,
    output dcsp_codec_s [1:0] codec
);

    dcsp_state_s st_reg;
    dcsp_state_s st_next;

    logic [2:0] mdiv;
    logic [3:0] sdiv;
    logic [5:0] prod;
    logic [5:0] bitlen;
    logic [11:0] speriod;
    logic mtick;
    logic bit_end;
    logic sevt;
    logic [15:0] dgt0;

    // Mode from the port mode register
    function automatic dcsp_mode_e mode_of(input dcsp_byte_t a);
        if (!a[`DCSP_MODE_DATA]) begin
            return DCSP_CTRL;
        end else if (a[`DCSP_MODE_MIXED]) begin
            return DCSP_MIXED;
        end
        return DCSP_DATA;
    endfunction

    // Master divider ratio, illegal codes give one
    function automatic logic [2:0] mdiv_of(input logic [2:0] c);
        return (c > 3'h4) ? 3'h1 : 3'(c + 3'h1);
    endfunction

    // Serial divider ratio, code 00 slowest
    function automatic logic [3:0] sdiv_of(input logic [1:0] c);
        return 4'h8 >> c;
    endfunction

    // Output gain in dB, 3 dB per code step
    function automatic logic signed [4:0] ogs_of(input logic [2:0] c);
        return `DCSP_OGS_TOP_DB - $signed({2'b00, c})
            - $signed({1'b0, c, 1'b0});
    endfunction

    // Analog tap gain in sixteenths
    function automatic logic signed [5:0] agt_of(input logic [4:0] c);
        if (c[4]) begin
            return 6'sd0 - $signed({2'b00, c[3:0]}) - 6'sd1;
        end
        return `DCSP_AGT_UNITY - $signed({2'b00, c[3:0]});
    endfunction

    // Encoder word placed into the shift register
    function automatic logic [15:0] enc_of(input dcsp_mode_e m,
                                           input logic [15:0] s);
        unique case (m)
            DCSP_DATA: return s;
            DCSP_MIXED: return {1'b0, s[15:1]};
            default: return 16'h0000;
        endcase
    endfunction

    // Clock dividers driven by codec one settings
    assign mdiv = mdiv_of(
        st_reg.regs[0][`DCSP_REG_B][`DCSP_MCD_LSB +: 3]);
    assign sdiv = sdiv_of(
        st_reg.regs[0][`DCSP_REG_B][`DCSP_SCD_LSB +: 2]);
    assign prod = 6'(mdiv * sdiv);
    assign bitlen = (prod < `DCSP_BIT_MIN_CYC) ? `DCSP_BIT_MIN_CYC : prod;
    assign speriod = `DCSP_SR_MIN_TICKS
        << (2'd3 - st_reg.regs[0][`DCSP_REG_B][`DCSP_SR_LSB +: 2]);

    // Internal master clock tick, bit end, sample event
    assign mtick = st_reg.mcnt >= (mdiv - 3'h1);
    assign bit_end = (st_reg.phase == DCSP_SHIFT)
        && (st_reg.bcnt >= (bitlen - 6'h1));
    assign sevt = mtick && (st_reg.srcnt >= (speriod - 12'h1));
    assign dgt0 = {st_reg.regs[0][`DCSP_REG_G], st_reg.regs[0][`DCSP_REG_H]};

    // Next state of the whole block
    always_comb begin
        logic [15:0] w;
        dcsp_mode_e m;
        logic signed [15:0] digital_feedback_tap;
        dcsp_byte_t rc;
        dcsp_byte_t rd;
        dcsp_byte_t rf;
        w = 16'h0000;
        m = DCSP_CTRL;
        digital_feedback_tap = 16'sh0000;
        rc = 8'h00;
        rd = 8'h00;
        rf = 8'h00;
        st_next = st_reg;
        st_next.sdi_m = sdi;
        st_next.sdi_s = st_reg.sdi_m;
        st_next.sdofs = 1'b0;
        st_next.rdata = 8'h00;

        // Internal clock and sample rate counters
        st_next.mcnt = mtick ? 3'h0 : st_reg.mcnt + 3'h1;
        if (mtick) begin
            st_next.srcnt = sevt ? 12'h000 : st_reg.srcnt + 12'h001;
        end

        // Bit timing and shifting of the cascade
        if (st_reg.phase == DCSP_SHIFT) begin
            st_next.bcnt = bit_end ? 6'h00 : st_reg.bcnt + 6'h01;
            st_next.sclk = st_next.bcnt < {1'b0, bitlen[5:1]};
            if (bit_end) begin
                st_next.sh[0] = {st_reg.sh[0][14:0], st_reg.sdi_s};
                st_next.sh[1] = {st_reg.sh[1][14:0], st_reg.sh[0][15]};
                st_next.bitcnt = st_reg.bitcnt + 5'h01;
                st_next.sdo = st_next.sh[1][15];
                st_next.sdofs = st_next.bitcnt[3:0] == 4'h0;
                if (st_reg.bitcnt == `DCSP_LAST_BIT) begin
                    st_next.phase = DCSP_IDLE;
                    st_next.sclk = 1'b0;
                    st_next.sdofs = 1'b0;
                    // Act on the word each codec now holds
                    for (int c = 0; c < 2; c++) begin
                        w = st_next.sh[c];
                        m = mode_of(st_reg.regs[c][`DCSP_REG_A]);
                        if (w[`DCSP_CD_BIT] && m != DCSP_DATA) begin
                            if (w[`DCSP_DEV_LSB +: 3] == 3'h0) begin
                                if (!w[`DCSP_RW_BIT]) begin
                                    st_next.regs[c][w[`DCSP_ADR_LSB +: 3]] =
                                        w[7:0];
                                end else begin
                                    st_next.rb_vld[c] = 1'b1;
                                    st_next.rb_word[c] = {w[15:8],
                                        st_reg.regs[c][w[`DCSP_ADR_LSB +: 3]]};
                                end
                            end
                        end else if (m == DCSP_DATA) begin
                            st_next.cout[c].dac_word = w;
                        end else if (m == DCSP_MIXED) begin
                            st_next.cout[c].dac_word = {w[14:0], 1'b0};
                        end
                    end
                end
            end
        end

        // Sample event opens a new exchange, overwriting the register
        if (sevt) begin
            st_next.phase = DCSP_SHIFT;
            st_next.bitcnt = 5'h00;
            st_next.bcnt = 6'h00;
            st_next.sclk = 1'b1;
            st_next.sdofs = 1'b1;
            for (int c = 0; c < 2; c++) begin
                m = mode_of(st_reg.regs[c][`DCSP_REG_A]);
                st_next.sh[c] = st_next.rb_vld[c] ? st_next.rb_word[c]
                    : enc_of(m, enc_sample[c]);
                st_next.rb_vld[c] = 1'b0;
            end
            st_next.sdo = st_next.sh[1][15];
        end

        // Register port, a local write wins over a serial one
        if (bus.wr && !bus.addr[4]) begin
            st_next.regs[bus.addr[3]][bus.addr[2:0]] = bus.wdata;
        end
        if (bus.rd) begin
            if (!bus.addr[4]) begin
                st_next.rdata = st_reg.regs[bus.addr[3]][bus.addr[2:0]];
            end else if (bus.addr == `DCSP_STATUS_ADDR) begin
                st_next.rdata = {5'h00, st_reg.rb_vld, st_reg.phase};
            end
        end

        // Analog and tap controls of each codec
        for (int c = 0; c < 2; c++) begin
            rc = st_reg.regs[c][`DCSP_REG_C];
            rd = st_reg.regs[c][`DCSP_REG_D];
            rf = st_reg.regs[c][`DCSP_REG_F];
            st_next.cout[c].out_gain_db =
                ogs_of(rd[`DCSP_OGS_LSB +: 3]);
            st_next.cout[c].out_mute = rd[`DCSP_MUTE];
            st_next.cout[c].ref_out_en = rc[`DCSP_REFOUT];
            st_next.cout[c].agt_connect =
                rc[`DCSP_AGT_PWR] && rf[`DCSP_AGT_EN];
            st_next.cout[c].agt_gain =
                (rc[`DCSP_AGT_PWR] && !rf[`DCSP_AGT_MUTE])
                ? agt_of(rf[4:0]) : 6'sd0;
            digital_feedback_tap = $signed({st_reg.regs[c][`DCSP_REG_G],
                st_reg.regs[c][`DCSP_REG_H]});
            st_next.cout[c].dgt_sum = enc_bit[c]
                ? $signed(interp_word[c]) + digital_feedback_tap
                : $signed(interp_word[c]) - digital_feedback_tap;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg <= '0;
            st_reg.regs <= {16{`DCSP_REG_RST}};
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register
    assign rdata = st_reg.rdata;
    assign sclk = st_reg.sclk;
    assign sdofs = st_reg.sdofs;
    assign sdo = st_reg.sdo;
    assign codec = st_reg.cout;

    // Word frames only mark word starts of an exchange
    frame_start_a: assert property (@(posedge clk) disable iff (sys_rst)
        st_reg.sdofs |-> st_reg.phase == DCSP_SHIFT
            && st_reg.bitcnt[3:0] == 4'h0)
        else $error("word frame outside a word start");

    // Sample event loads the data-mode encoder word
    load_word_a: assert property (@(posedge clk) disable iff (sys_rst)
        sevt && !st_reg.rb_vld[1]
            && mode_of(st_reg.regs[1][`DCSP_REG_A]) == DCSP_DATA
        |=> st_reg.sh[1] == $past(enc_sample[1])
            && st_reg.sdo == $past(enc_sample[1][15]))
        else $error("encoder word not loaded at sample event");

    // Output bit follows the MSB-first chain
    msb_first_a: assert property (@(posedge clk) disable iff (sys_rst)
        bit_end && !sevt && st_reg.bitcnt != `DCSP_LAST_BIT
        |=> st_reg.sdo == $past(st_reg.sh[1][14]))
        else $error("serial output not MSB first");

    // Mixed mode keeps the flag bit clear on samples
    mixed_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
        sevt && !st_next.rb_vld[0]
            && mode_of(st_reg.regs[0][`DCSP_REG_A]) == DCSP_MIXED
        |=> !st_reg.sh[0][15])
        else $error("mixed sample carries flag bit");

    // Lowest gain code reaches -15 dB
    out_gain_a: assert property (@(posedge clk) disable iff (sys_rst)
        st_reg.regs[0][`DCSP_REG_D][`DCSP_OGS_LSB +: 3] == 3'h7
        ##1 $stable(st_reg.regs[0][`DCSP_REG_D])
        |=> codec[0].out_gain_db == -5'sd15)
        else $error("output gain code 7 not -15 dB");

    // Mute bit reaches the output
    out_mute_a: assert property (@(posedge clk) disable iff (sys_rst)
        $past(st_reg.regs[0][`DCSP_REG_D][`DCSP_MUTE]) |-> codec[0].out_mute)
        else $error("mute not applied");

    // Reference output follows its enable
    ref_out_a: assert property (@(posedge clk) disable iff (sys_rst)
        codec[1].ref_out_en
        |-> $past(st_reg.regs[1][`DCSP_REG_C][`DCSP_REFOUT]))
        else $error("reference output without enable");

    // Unpowered analog tap stays off
    agt_off_a: assert property (@(posedge clk) disable iff (sys_rst)
        !$past(st_reg.regs[0][`DCSP_REG_C][`DCSP_AGT_PWR])
        |-> !codec[0].agt_connect && codec[0].agt_gain == 6'sd0)
        else $error("analog tap active without power");

    // Tap mute forces zero gain
    agt_mute_a: assert property (@(posedge clk) disable iff (sys_rst)
        $past(st_reg.regs[0][`DCSP_REG_F][`DCSP_AGT_MUTE])
        |-> codec[0].agt_gain == 6'sd0)
        else $error("muted tap has nonzero gain");

    // Digital tap added on a one bit
    dgt_sum_a: assert property (@(posedge clk) disable iff (sys_rst)
        $past(enc_bit[0]) |-> codec[0].dgt_sum
            == $signed($past(interp_word[0])) + $signed($past(dgt0)))
        else $error("digital tap not added");

endmodule // dcsp_ctrl

// [hw/dcsp_defs.svh]
// Constants of the dual codec serial port controller
`ifndef DCSP_DEFS_SVH
`define DCSP_DEFS_SVH
`define DCSP_REG_A 3'h0
`define DCSP_REG_B 3'h1
`define DCSP_REG_C 3'h2
`define DCSP_REG_D 3'h3
`define DCSP_REG_F 3'h5
`define DCSP_REG_G 3'h6
`define DCSP_REG_H 3'h7
`define DCSP_REG_RST 8'h00
`define DCSP_STATUS_ADDR 5'h10
`define DCSP_MODE_DATA 0
`define DCSP_MODE_MIXED 1
`define DCSP_SR_LSB 0
`define DCSP_SCD_LSB 2
`define DCSP_MCD_LSB 4
`define DCSP_AGT_PWR 1
`define DCSP_REFOUT 6
`define DCSP_OGS_LSB 4
`define DCSP_MUTE 7
`define DCSP_AGT_EN 5
`define DCSP_AGT_MUTE 7
`define DCSP_CD_BIT 15
`define DCSP_RW_BIT 14
`define DCSP_DEV_LSB 11
`define DCSP_ADR_LSB 8
`define DCSP_OGS_TOP_DB 5'sd6
`define DCSP_AGT_UNITY 6'sd16
`define DCSP_SR_MIN_TICKS 12'd256
`define DCSP_BIT_MIN_CYC 6'd4
`define DCSP_LAST_BIT 5'd31
`endif

// [hw/dcsp_pkg.sv]
// Types of the dual codec serial port controller
package dcsp_pkg;
    typedef enum logic [1:0] {
        DCSP_CTRL = 2'b00,
        DCSP_DATA = 2'b01,
        DCSP_MIXED = 2'b11
    } dcsp_mode_e;
    typedef enum logic {
        DCSP_IDLE = 1'b0,
        DCSP_SHIFT = 1'b1
    } dcsp_phase_e;
    typedef logic [7:0] dcsp_byte_t;
    typedef struct packed {
        logic [15:0] dac_word;
        logic signed [4:0] out_gain_db;
        logic out_mute;
        logic ref_out_en;
        logic agt_connect;
        logic signed [5:0] agt_gain;
        logic signed [16:0] dgt_sum;
    } dcsp_codec_s;
    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } dcsp_bus_s;
    typedef struct packed {
        dcsp_byte_t [1:0][7:0] regs;
        logic [1:0][15:0] sh;
        logic [1:0] rb_vld;
        logic [1:0][15:0] rb_word;
        dcsp_phase_e phase;
        logic [4:0] bitcnt;
        logic [5:0] bcnt;
        logic [2:0] mcnt;
        logic [11:0] srcnt;
        logic sdi_m;
        logic sdi_s;
        logic sclk;
        logic sdofs;
        logic sdo;
        logic [7:0] rdata;
        dcsp_codec_s [1:0] cout;
    } dcsp_state_s;
endpackage
